// [mul_div_mac_unit.v]
`timescale 1ns/1ns
`include "mdu_defs.vh"

// Summary of operation
// - 8-bit control register, cleared to zero by reset.
// - Control register writable as whole byte or as single bit.
// - Bits 7,6,3 select unsigned/signed multiply or multiply-accumulate.
// - Bit 7 set, bit 3 clear: unsigned divide; interrupt only if bit 6 clear.
// - Unsigned accumulate overflows when sum leaves the 32-bit unsigned range.
// - Signed accumulate overflows when like-signed addends give opposite sign.
// - Sign flag shows accumulator sign bit in signed multiply-accumulate mode, zero otherwise.
// - Sign and overflow flag bits ignore software writes to the control register.
// - Start bit settable only in divide mode; starts division, reads one while busy.
// - Hardware clears the start bit when the division finishes.
// - Software cannot clear the start bit during a division.
// - Multiply starts by itself once both operand halves are written.
// - Product lands in the B registers one clock after the operands.
// - Multiply-accumulate starts on the write of the A high half.
// - Product in B after one clock, added into C one clock later.
// - Accumulate overflow sets the overflow flag and raises the interrupt.
// - Signed multiply-accumulate mode: C high write copies its bit 15 into sign flag; final positive value clears it.
// - A division completes within sixteen clocks of its start.
// - Dividend comes from the A registers, the quotient returns there.
// - C holds the accumulator, and the remainder after a division.
module mul_div_mac_unit (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire [`MDU_ADDR_W-1:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire bit_wr_i,
   input wire [2:0] bit_sel_i,
   input wire rd_i,
   output wire [15:0] rdata_o,
   output wire muldiv_done_irq_o
);

   // ****************************************
   // State
   // ****************************************
   reg div_sel_ff;
   reg acc_sel_ff;
   reg sgn_sel_ff;
   reg ovf_ff;
   reg sign_ff;
   reg busy_ff;
   reg [15:0] a_lo_ff;
   reg [15:0] a_hi_ff;
   reg [15:0] b_lo_ff;
   reg [15:0] b_hi_ff;
   reg [15:0] c_lo_ff;
   reg [15:0] c_hi_ff;
   reg a_lo_seen_ff;
   reg a_hi_seen_ff;
   reg mul_go_ff;
   reg mac1_ff;
   reg mac2_ff;
   reg irq_ff;
   reg [15:0] rdata_ff;

   // ****************************************
   // Address decode
   // ****************************************
   wire wr_ctl = wr_i && (addr_i == `MDU_CTL_ADDR);
   wire wr_wide = wr_i && !bit_wr_i;
   wire wr_alo = wr_wide && (addr_i == `MDU_A_LO_ADDR);
   wire wr_ahi = wr_wide && (addr_i == `MDU_A_HI_ADDR);
   wire wr_blo = wr_wide && (addr_i == `MDU_B_LO_ADDR);
   wire wr_bhi = wr_wide && (addr_i == `MDU_B_HI_ADDR);
   wire wr_clo = wr_wide && (addr_i == `MDU_C_LO_ADDR);
   wire wr_chi = wr_wide && (addr_i == `MDU_C_HI_ADDR);

   // ****************************************
   // Control register view and write merge
   // ****************************************
   wire signed_mac = acc_sel_ff && sgn_sel_ff && !div_sel_ff;
   wire [7:0] ctl_view = {div_sel_ff, acc_sel_ff, 2'b00, sgn_sel_ff, ovf_ff,
      sign_ff && signed_mac, busy_ff};
   reg [7:0] wval;

   always @* begin
      if (bit_wr_i) begin
         wval = ctl_view;
         wval[bit_sel_i] = wdata_i[0];
      end else begin
         wval = wdata_i[7:0];
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   wire mode_mul = !div_sel_ff && !acc_sel_ff;
   wire mode_mac = !div_sel_ff && acc_sel_ff;
   wire div_start = wr_ctl && wval[`MDU_CTL_BUSY_BIT] && wval[`MDU_CTL_DIV_BIT]
      && !wval[`MDU_CTL_SGN_BIT] && !busy_ff;

   // Multiply waits until both halves have been seen at least once
   wire nxt_lo_seen = a_lo_seen_ff || wr_alo;
   wire nxt_hi_seen = a_hi_seen_ff || wr_ahi;
   wire mul_trig = mode_mul && (wr_alo || wr_ahi) && nxt_lo_seen && nxt_hi_seen;
   wire mac_trig = mode_mac && wr_ahi;

   // ****************************************
   // Arithmetic
   // ****************************************
   wire [31:0] prod_u = a_hi_ff * a_lo_ff;
   wire signed [31:0] prod_s = $signed(a_hi_ff) * $signed(a_lo_ff);
   wire [31:0] prod = sgn_sel_ff ? prod_s : prod_u;
   wire [31:0] acc_old = {c_hi_ff, c_lo_ff};
   wire [31:0] addend = {b_hi_ff, b_lo_ff};
   wire [32:0] sum = {1'b0, acc_old} + {1'b0, addend};
   wire ovf_u = sum[32];
   wire ovf_s = (acc_old[31] == addend[31]) && (sum[31] != acc_old[31]);
   wire acc_ovf = sgn_sel_ff ? ovf_s : ovf_u;

   // ****************************************
   // Divider
   // ****************************************
   wire [31:0] quo;
   wire [31:0] rem;
   wire div_done;

   mdu_divider u_div (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .start_i(div_start),
      .dividend_i({a_hi_ff, a_lo_ff}),
      .divisor_i({b_hi_ff, b_lo_ff}),
      .quotient_o(quo),
      .remainder_o(rem),
      .done_o(div_done)
   );

   // ****************************************
   // Control register
   // ****************************************
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_sel_ff <= 1'b0;
         acc_sel_ff <= 1'b0;
         sgn_sel_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         if (wr_ctl) begin
            div_sel_ff <= wval[`MDU_CTL_DIV_BIT];
            acc_sel_ff <= wval[`MDU_CTL_ACC_BIT];
            sgn_sel_ff <= wval[`MDU_CTL_SGN_BIT];
         end
         // Software clear of the busy bit has no path here
         if (div_done) begin
            busy_ff <= 1'b0;
         end else if (div_start) begin
            busy_ff <= 1'b1;
         end
      end
   end

   // Flags ignore control writes; sign flag also loads from C high writes in signed MAC mode
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ovf_ff <= 1'b0;
         sign_ff <= 1'b0;
      end else begin
         if (mac2_ff) begin
            ovf_ff <= acc_ovf;
            sign_ff <= sgn_sel_ff && sum[31];
         end else if (wr_chi && signed_mac) begin
            sign_ff <= wdata_i[15];
         end
      end
   end

   // ****************************************
   // Operation sequencing
   // ****************************************
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         a_lo_seen_ff <= 1'b0;
         a_hi_seen_ff <= 1'b0;
         mul_go_ff <= 1'b0;
         mac1_ff <= 1'b0;
         mac2_ff <= 1'b0;
      end else begin
         a_lo_seen_ff <= nxt_lo_seen;
         a_hi_seen_ff <= nxt_hi_seen;
         mul_go_ff <= mul_trig || mac_trig;
         mac1_ff <= mac_trig;
         mac2_ff <= mac1_ff;
      end
   end

   // ****************************************
   // Data registers
   // ****************************************
   // Hardware results win over software writes landing in the same clock
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         a_lo_ff <= `MDU_DATA_RST;
         a_hi_ff <= `MDU_DATA_RST;
      end else if (div_done) begin
         a_hi_ff <= quo[31:16];
         a_lo_ff <= quo[15:0];
      end else begin
         if (wr_alo) begin
            a_lo_ff <= wdata_i;
         end
         if (wr_ahi) begin
            a_hi_ff <= wdata_i;
         end
      end
   end

   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         b_lo_ff <= `MDU_DATA_RST;
         b_hi_ff <= `MDU_DATA_RST;
      end else if (mul_go_ff) begin
         b_hi_ff <= prod[31:16];
         b_lo_ff <= prod[15:0];
      end else begin
         if (wr_blo) begin
            b_lo_ff <= wdata_i;
         end
         if (wr_bhi) begin
            b_hi_ff <= wdata_i;
         end
      end
   end

   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         c_lo_ff <= `MDU_DATA_RST;
         c_hi_ff <= `MDU_DATA_RST;
      end else if (div_done) begin
         c_hi_ff <= rem[31:16];
         c_lo_ff <= rem[15:0];
      end else if (mac2_ff) begin
         // Wraps modulo 2^32; overflow is reported through the flag
         c_hi_ff <= sum[31:16];
         c_lo_ff <= sum[15:0];
      end else begin
         if (wr_clo) begin
            c_lo_ff <= wdata_i;
         end
         if (wr_chi) begin
            c_hi_ff <= wdata_i;
         end
      end
   end

   // ****************************************
   // Completion interrupt
   // ****************************************
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (mac2_ff && acc_ovf)
            || (div_done && !acc_sel_ff);
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_ff <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            `MDU_CTL_ADDR: begin
               rdata_ff <= {8'h00, ctl_view};
            end
            `MDU_A_LO_ADDR: begin
               rdata_ff <= a_lo_ff;
            end
            `MDU_A_HI_ADDR: begin
               rdata_ff <= a_hi_ff;
            end
            `MDU_B_LO_ADDR: begin
               rdata_ff <= b_lo_ff;
            end
            `MDU_B_HI_ADDR: begin
               rdata_ff <= b_hi_ff;
            end
            `MDU_C_LO_ADDR: begin
               rdata_ff <= c_lo_ff;
            end
            `MDU_C_HI_ADDR: begin
               rdata_ff <= c_hi_ff;
            end
            default: begin
               rdata_ff <= 16'h0000;
            end
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign rdata_o = rdata_ff;
   assign muldiv_done_irq_o = irq_ff;

endmodule

// [mdu_defs.vh]
`ifndef MDU_DEFS_VH
`define MDU_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define MDU_ADDR_W 20
`define MDU_CTL_ADDR 20'h000E8
`define MDU_A_LO_ADDR 20'hFFFF0
`define MDU_A_HI_ADDR 20'hFFFF2
`define MDU_B_LO_ADDR 20'hFFFF4
`define MDU_B_HI_ADDR 20'hFFFF6
`define MDU_C_LO_ADDR 20'hF00E0
`define MDU_C_HI_ADDR 20'hF00E2

// ****************************************
// Control register fields
// ****************************************
`define MDU_CTL_DIV_BIT 7
`define MDU_CTL_ACC_BIT 6
`define MDU_CTL_SGN_BIT 3
`define MDU_CTL_OVF_BIT 2
`define MDU_CTL_SIGNF_BIT 1
`define MDU_CTL_BUSY_BIT 0

// ****************************************
// Reset values
// ****************************************
`define MDU_CTL_RST 8'h00
`define MDU_DATA_RST 16'h0000

// ****************************************
// Timing
// ****************************************
`define MDU_DIV_CLOCKS 16
`define MDU_DIV_LAST 4'hF

`endif

// [mdu_divider.v]
`timescale 1ns/1ns
`include "mdu_defs.vh"

// Unsigned 32/32 restoring divider, two quotient bits per clock
module mdu_divider (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire start_i,
   input wire [31:0] dividend_i,
   input wire [31:0] divisor_i,
   output wire [31:0] quotient_o,
   output wire [31:0] remainder_o,
   output wire done_o
);

   reg [63:0] work_ff;
   reg [31:0] dvs_ff;
   reg [3:0] cnt_ff;
   reg run_ff;
   reg done_ff;

   // ****************************************
   // One restoring step on {remainder, quotient}
   // ****************************************
   function [63:0] div_step;
      input [63:0] rq;
      input [31:0] d;
      reg [32:0] r;
      begin
         r = {rq[63:31]};
         if (r >= {1'b0, d}) begin
            r = r - {1'b0, d};
            div_step = {r[31:0], rq[30:0], 1'b1};
         end else begin
            div_step = {r[31:0], rq[30:0], 1'b0};
         end
      end
   endfunction

   // Zero divisor gives all-ones quotient; caller must not rely on it
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         work_ff <= 64'h0000000000000000;
         dvs_ff <= 32'h00000000;
         cnt_ff <= 4'h0;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start_i) begin
            // First pair of steps happens on the load edge
            dvs_ff <= divisor_i;
            work_ff <= div_step(div_step({32'h00000000, dividend_i}, divisor_i), divisor_i);
            cnt_ff <= 4'h1;
            run_ff <= 1'b1;
         end else if (run_ff) begin
            work_ff <= div_step(div_step(work_ff, dvs_ff), dvs_ff);
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == `MDU_DIV_LAST) begin
               run_ff <= 1'b0;
               done_ff <= 1'b1;
            end
         end
      end
   end

   assign quotient_o = work_ff[31:0];
   assign remainder_o = work_ff[63:32];
   assign done_o = done_ff;

endmodule

// [mul_div_mac_unit_assertions.sv]
`timescale 1ns/1ns
`include "mdu_defs.vh"
module mdu_checker (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire [`MDU_ADDR_W-1:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire bit_wr_i,
   input wire [2:0] bit_sel_i,
   input wire rd_i,
   input wire [15:0] rdata_o,
   input wire muldiv_done_irq_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);
   wire ctl_wr = wr_i && !bit_wr_i && addr_i == `MDU_CTL_ADDR;
   wire ctl_rd = rd_i && addr_i == `MDU_CTL_ADDR;
   wire a_hi_wr = wr_i && addr_i == `MDU_A_HI_ADDR;
   wire div_irq = ctl_wr && wdata_i[7:0] == 8'h81;
   wire bit_go = wr_i && bit_wr_i && addr_i == `MDU_CTL_ADDR && bit_sel_i == 3'h0
      && wdata_i[0];
   wire div_kick = div_irq || bit_go;
   // ****************************************
   // Sequences
   // ****************************************
   sequence div_start_s;
      ctl_wr && wdata_i[7] && wdata_i[0] && !wdata_i[3];
   endsequence
   sequence c_hi_neg_s;
      wr_i && addr_i == `MDU_C_HI_ADDR && wdata_i[15];
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   ctl_reserved_zero_a: assert property ($past(ctl_rd) |-> rdata_o[15:8] == 8'h00
      && rdata_o[5:4] == 2'b00) else $error("reserved control bits not zero");
   irq_one_pulse_a: assert property (muldiv_done_irq_o |=> !muldiv_done_irq_o)
      else $error("interrupt longer than one clock");
   div_irq_a: assert property (div_irq |-> ##17 muldiv_done_irq_o)
      else $error("no interrupt after division");
   div_quiet_a: assert property (ctl_wr && wdata_i[7:0] == 8'hC1 |-> ##17 !muldiv_done_irq_o)
      else $error("interrupt with accumulate bit set");
   busy_high_a: assert property (div_start_s ##[1:15] ctl_rd |=> rdata_o[0])
      else $error("busy low during division");
   busy_done_a: assert property (div_start_s ##17 ctl_rd |=> !rdata_o[0])
      else $error("busy still set after division");
   sign_set_a: assert property (ctl_wr && wdata_i[7:0] == 8'h48 ##[1:4] c_hi_neg_s
      ##[1:4] ctl_rd |=> rdata_o[1]) else $error("sign flag not set");
   sign_unsigned_a: assert property (ctl_wr && wdata_i[7:0] == 8'h40 ##[1:4] c_hi_neg_s
      ##[1:4] ctl_rd |=> !rdata_o[1]) else $error("sign flag set in unsigned mode");
   irq_cause_a: assert property (muldiv_done_irq_o |-> $past(a_hi_wr, 3)
      || $past(div_kick, 17)) else $error("interrupt without cause");
endmodule
bind mul_div_mac_unit mdu_checker u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .bit_wr_i(bit_wr_i),
   .bit_sel_i(bit_sel_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .muldiv_done_irq_o(muldiv_done_irq_o));

// [tb_mul_div_mac_unit.sv]
`timescale 1ns/1ns
`include "mdu_defs.vh"
module tb_mul_div_mac_unit;
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [`MDU_ADDR_W-1:0] addr_i = 20'h00000;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic bit_wr_i = 1'b0;
   logic [2:0] bit_sel_i = 3'h0;
   logic rd_i = 1'b0;
   wire [15:0] rdata_o;
   wire muldiv_done_irq_o;
   int fails = 0;
   int n_tests = 0;
   int irq_cnt = 0;
   // Row: mode, A lo, C hi, ctl, C lo, A hi, C hi, C lo, B hi, B lo, ctl, irqs
   logic [15:0] mac_tab [4][12] = '{
      '{16'h0040, 16'h7FFF, 16'hFFFF, 16'h0040, 16'h0002, 16'h0002,
        16'h0000, 16'h0000, 16'h0000, 16'hFFFE, 16'h0044, 16'h0001},
      '{16'h0040, 16'h0003, 16'h0000, 16'h0044, 16'h0003, 16'h0002,
        16'h0000, 16'h0009, 16'h0000, 16'h0006, 16'h0040, 16'h0000},
      '{16'h0048, 16'h7FFF, 16'h8000, 16'h004A, 16'h0001, 16'hFFFF,
        16'h7FFF, 16'h8002, 16'hFFFF, 16'h8001, 16'h004C, 16'h0001},
      '{16'h0048, 16'h0003, 16'hFFFF, 16'h004E, 16'hFFFC, 16'h0002,
        16'h0000, 16'h0002, 16'h0000, 16'h0006, 16'h0048, 16'h0000}};
   mul_div_mac_unit DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .muldiv_done_irq_o(muldiv_done_irq_o));
   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      if (muldiv_done_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
   end
   // ****************************************
   // Bus tasks and compares
   // ****************************************
   // Each access waits an edge first, so no strobe is assigned twice in one step
   task automatic wr16(input logic [19:0] a, input logic [15:0] d, input logic b = 1'b0);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      bit_wr_i <= b;
      bit_sel_i <= d[6:4];
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      bit_wr_i <= 1'b0;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [19:0] a, input logic [15:0] exp);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask
   task automatic ichk(input int exp);
      n_tests++;
      if (irq_cnt != exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %0d interrupts, expected %0d", $time, irq_cnt, exp);
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      rchk(`MDU_CTL_ADDR, 16'h0000);
      rchk(`MDU_A_HI_ADDR, 16'h0000);
      rchk(`MDU_B_LO_ADDR, 16'h0000);
      rchk(`MDU_C_HI_ADDR, 16'h0000);
      rchk(20'h00100, 16'h0000);
      $display("t_reset done");
   endtask
   task automatic t_ctl;
      // Bit write word: {bit index in [6:4], value in [0]}, then expected control
      logic [15:0] bw [8] = '{16'h0061, 16'h0031, 16'h0051, 16'h0021, 16'h0001,
         16'h0030, 16'h0071, 16'h0060};
      logic [15:0] ex [8] = '{16'h0040, 16'h0048, 16'h0048, 16'h0048, 16'h0048,
         16'h0040, 16'h00C0, 16'h0080};
      wr16(`MDU_CTL_ADDR, 16'h00FF);
      rchk(`MDU_CTL_ADDR, 16'h00C8);
      wr16(`MDU_CTL_ADDR, 16'h0001);
      rchk(`MDU_CTL_ADDR, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr16(`MDU_CTL_ADDR, bw[i], 1'b1);
         rchk(`MDU_CTL_ADDR, ex[i]);
      end
      wr16(`MDU_CTL_ADDR, 16'h0000);
      $display("t_ctl done");
   endtask
   task automatic t_mul;
      logic [15:0] mode [2] = '{16'h0000, 16'h0008};
      logic [15:0] alo [2] = '{16'hFFFF, 16'hFFFE};
      logic [15:0] ahi [2] = '{16'h0002, 16'h7FFF};
      logic [31:0] prod [2] = '{32'h0001FFFE, 32'hFFFF0002};
      int irq0;
      irq0 = irq_cnt;
      for (int i = 0; i < 2; i++) begin
         wr16(`MDU_CTL_ADDR, mode[i]);
         wr16(`MDU_A_LO_ADDR, alo[i]);
         wr16(`MDU_A_HI_ADDR, ahi[i]);
         rchk(`MDU_B_LO_ADDR, prod[i][15:0]);
         rchk(`MDU_B_HI_ADDR, prod[i][31:16]);
      end
      ichk(irq0);
      $display("t_mul done");
   endtask
   task automatic t_mac;
      int irq0;
      for (int i = 0; i < 4; i++) begin
         irq0 = irq_cnt;
         wr16(`MDU_CTL_ADDR, mac_tab[i][0]);
         wr16(`MDU_A_LO_ADDR, mac_tab[i][1]);
         wr16(`MDU_C_HI_ADDR, mac_tab[i][2]);
         rchk(`MDU_CTL_ADDR, mac_tab[i][3]);
         wr16(`MDU_C_LO_ADDR, mac_tab[i][4]);
         wr16(`MDU_A_HI_ADDR, mac_tab[i][5]);
         @(posedge clk_sys_i);
         rchk(`MDU_C_HI_ADDR, mac_tab[i][6]);
         rchk(`MDU_C_LO_ADDR, mac_tab[i][7]);
         rchk(`MDU_B_HI_ADDR, mac_tab[i][8]);
         rchk(`MDU_B_LO_ADDR, mac_tab[i][9]);
         rchk(`MDU_CTL_ADDR, mac_tab[i][10]);
         ichk(irq0 + mac_tab[i][11]);
      end
      $display("t_mac done");
   endtask
   task automatic t_div;
      int irq0;
      irq0 = irq_cnt;
      wr16(`MDU_CTL_ADDR, 16'h0080);
      wr16(`MDU_A_HI_ADDR, 16'h0001);
      wr16(`MDU_A_LO_ADDR, 16'h86A3);
      wr16(`MDU_B_HI_ADDR, 16'h0000);
      wr16(`MDU_B_LO_ADDR, 16'h000A);
      wr16(`MDU_CTL_ADDR, 16'h0081);
      wr16(`MDU_CTL_ADDR, 16'h0080);
      rchk(`MDU_CTL_ADDR, 16'h0081);
      // Next read lands in the first cycle after the sixteenth
      repeat (11) @(posedge clk_sys_i);
      rchk(`MDU_CTL_ADDR, 16'h0080);
      rchk(`MDU_A_HI_ADDR, 16'h0000);
      rchk(`MDU_A_LO_ADDR, 16'h2710);
      rchk(`MDU_C_LO_ADDR, 16'h0003);
      ichk(irq0 + 1);
      wr16(`MDU_CTL_ADDR, 16'h00C1);
      repeat (15) @(posedge clk_sys_i);
      rchk(`MDU_CTL_ADDR, 16'h00C0);
      rchk(`MDU_A_LO_ADDR, 16'h03E8);
      rchk(`MDU_C_LO_ADDR, 16'h0000);
      ichk(irq0 + 1);
      // Start by single-bit write, interrupt enabled again
      wr16(`MDU_CTL_ADDR, 16'h0060, 1'b1);
      wr16(`MDU_CTL_ADDR, 16'h0001, 1'b1);
      rchk(`MDU_CTL_ADDR, 16'h0081);
      repeat (13) @(posedge clk_sys_i);
      rchk(`MDU_CTL_ADDR, 16'h0080);
      rchk(`MDU_A_LO_ADDR, 16'h0064);
      ichk(irq0 + 2);
      $display("t_div done");
   endtask
   task automatic t_rst2;
      // Mid-run reset must also forget which operand halves were seen
      @(posedge clk_sys_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      rchk(`MDU_CTL_ADDR, 16'h0000);
      rchk(`MDU_A_LO_ADDR, 16'h0000);
      rchk(`MDU_B_LO_ADDR, 16'h0000);
      wr16(`MDU_A_HI_ADDR, 16'h0003);
      rchk(`MDU_B_LO_ADDR, 16'h0000);
      wr16(`MDU_A_LO_ADDR, 16'h0005);
      rchk(`MDU_B_LO_ADDR, 16'h000F);
      $display("t_rst2 done");
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      t_reset;
      t_ctl;
      t_mul;
      t_mac;
      t_div;
      t_rst2;
      complete_run;
   end
   // Whole run needs well under a thousand clocks
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      fails++;
      complete_run;
   end
endmodule
